/* File: rtl/usasp_pkg.sv */
// shared types and constants of the serial port
package usasp_pkg;

    // serial mode selected by software
    typedef enum logic [1:0] {
        USASP_SHIFT   = 2'h0,
        USASP_ASYNC10 = 2'h1,
        USASP_FIXED11 = 2'h2,
        USASP_VAR11   = 2'h3
    } usasp_mode_t;

    // word queued by a write to serial_buffer
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } usasp_txw_t;

    localparam int TXW_BITS   = $bits(usasp_txw_t);
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [4:0] {
        TXS_IDLE  = 5'h01,
        TXS_WAIT  = 5'h02,
        TXS_START = 5'h04,
        TXS_DATA  = 5'h08,
        TXS_SHIFT = 5'h10
    } usasp_txs_t;

    typedef enum logic [2:0] {
        RXS_IDLE = 3'h1,
        RXS_BITS = 3'h2,
        RXS_HOLD = 3'h4
    } usasp_rxs_t;

    // divide-by-16 counter states
    localparam logic [3:0] CNT_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;

    localparam logic [8:0] RX_ASYNC_PRELOAD = 9'h1ff;
    localparam logic [8:0] RX_SHIFT_PRELOAD = 9'h1fe;
    localparam logic [7:0] TX_DONE_PATTERN  = 8'h01;
    localparam logic [7:0] SERIAL_BUFFER_RESET       = 8'h00;

    // rollovers from the write to the end of a frame
    localparam logic [3:0] ROLLS_10 = 4'ha;
    localparam logic [3:0] ROLLS_11 = 4'hb;

endpackage

/* File: rtl/usasp_serial_port.sv */
// serial port: shift mode, 10-bit and 11-bit asynchronous modes
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module usasp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap only for power-of-two depths
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r  <= count_nxt;
            in_ready <= (count_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module usasp_serial_port (
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire usasp_pkg::usasp_mode_t MODE,
    input  wire logic                   THREE_WIRE_ENABLE,
    input  wire logic                   RX_ENABLE,
    input  wire logic                   MULTIPROC_GATE,
    input  wire logic                   DOUBLE_RATE_SELECT,
    input  wire logic                   TX_NINTH_BIT,
    input  wire logic                   TX_CLK_FROM_T2,
    input  wire logic                   RX_CLK_FROM_T2,
    input  wire logic                   T1_OVF,
    input  wire logic                   T2_OVF,
    input  wire logic                   WR_VALID,
    input  wire logic [7:0]             WR_DATA,
    output logic                        WR_READY,
    input  wire logic                   TX_DONE_CLR,
    input  wire logic                   RX_DONE_CLR,
    output logic [7:0]                  SERIAL_BUFFER,
    output logic                        RX_NINTH_BIT,
    output logic                        TX_DONE_FLAG,
    output logic                        RX_DONE_FLAG,
    output logic                        TX_ACTIVE,
    input  wire logic                   RXD_I,
    output logic                        RXD_O,
    output logic                        RXD_OE_N,
    output logic                        TXD_O,
    output logic                        TXD_OE_N,
    output logic                        PORT_ONE_BIT_FIVE,
    input  wire logic                   PORT_ONE_BIT_SIX,
    output logic                        PORT_ONE_BIT_SEVEN
);
    import usasp_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7 - i];
        return r;
    endfunction

    logic             rxd_s1_r, rxd_s2_r, din_s1_r, din_s2_r;
    logic             div2_r, half_r;
    logic             fixed_tick, tx_tick, rx_tick, m0_src, m0_half;
    logic [3:0]       tx_cnt_r, rx_cnt_r, roll_cnt_r;
    logic             tx_roll;
    usasp_txs_t       tx_state_r;
    logic [8:0]       tx_sr_r;
    logic             first_r, async_txd_r, m0_phase_r, m0_clk_r, m0_dat_r;
    logic             m0_idle, m0_three, m0_two;
    logic             tx_finish, tx_fill;
    usasp_txw_t       wr_word, fifo_word;
    logic [TXW_BITS-1:0] fifo_rdata;
    logic             fifo_valid, fifo_pop;
    usasp_rxs_t       rx_state_r;
    logic [8:0]       rx_sr_r, rx_shift_in;
    logic             rx_first_r, rx_last_r, smp_a_r, smp_b_r, rx_m0_r;
    logic             rx_bit, rx_fall, rx_decide, m0_sample;
    logic             m0_final, as_final, rx_load;
    logic [7:0]       rx_byte;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            din_s1_r <= 1'b1;
            din_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= RXD_I;
            rxd_s2_r <= rxd_s1_r;
            din_s1_r <= PORT_ONE_BIT_SIX;
            din_s2_r <= din_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate ticks: tx_tick and rx_tick run at 16x the bit rate
    assign fixed_tick = DOUBLE_RATE_SELECT | div2_r;
    assign m0_src     = TX_NINTH_BIT ? T1_OVF : 1'b1;
    assign m0_half    = m0_src & (DOUBLE_RATE_SELECT | half_r);

    always_comb begin
        tx_tick = TX_CLK_FROM_T2 ? T2_OVF : T1_OVF;
        rx_tick = RX_CLK_FROM_T2 ? T2_OVF : T1_OVF;
        if (MODE == USASP_FIXED11) begin
            tx_tick = fixed_tick;
            rx_tick = fixed_tick;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div2_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            div2_r <= ~div2_r;
            if (m0_src) begin
                half_r <= ~half_r;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_cnt_r <= '0;
        end else if (tx_tick) begin
            tx_cnt_r <= tx_cnt_r + 1'b1;
        end
    end
    assign tx_roll = tx_tick && (tx_cnt_r == CNT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // write queue in front of serial_buffer
    assign wr_word   = '{ninth: TX_NINTH_BIT, data: WR_DATA};
    assign fifo_word = usasp_txw_t'(fifo_rdata);
    assign fifo_pop  = fifo_valid && (tx_state_r == TXS_IDLE);

    usasp_fifo #(.WIDTH(TXW_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (WR_VALID),
        .in_data   (wr_word),
        .in_ready  (WR_READY),
        .out_valid (fifo_valid),
        .out_data  (fifo_rdata),
        .out_ready (tx_state_r == TXS_IDLE)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    assign m0_idle  = ~MULTIPROC_GATE;
    assign m0_three = (MODE == USASP_SHIFT) && THREE_WIRE_ENABLE;
    assign m0_two   = (MODE == USASP_SHIFT) && !THREE_WIRE_ENABLE;
    assign tx_fill  = MODE[1] && first_r;
    // before the first 11-bit shift the word itself may look like the end
    assign tx_finish = !tx_fill && (tx_sr_r[8:1] == TX_DONE_PATTERN) &&
                       (((tx_state_r == TXS_DATA) && tx_roll) ||
                        ((tx_state_r == TXS_SHIFT) && m0_half && m0_phase_r));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_state_r  <= TXS_IDLE;
            tx_sr_r     <= '0;
            first_r     <= 1'b0;
            async_txd_r <= 1'b1;
            m0_phase_r  <= 1'b0;
            m0_clk_r    <= 1'b1;
            m0_dat_r    <= 1'b1;
        end else begin
            if (tx_state_r != TXS_SHIFT) begin
                m0_clk_r <= m0_idle;
            end
            unique case (tx_state_r)
                TXS_IDLE: if (fifo_pop) begin
                    // marker one, or the ninth bit in 11-bit modes
                    tx_sr_r <= {MODE[1] ? fifo_word.ninth : 1'b1,
                                fifo_word.data};
                    first_r    <= 1'b1;
                    m0_phase_r <= 1'b0;
                    m0_dat_r   <= fifo_word.data[0];
                    tx_state_r <= (MODE == USASP_SHIFT) ? TXS_SHIFT : TXS_WAIT;
                end
                TXS_WAIT: if (tx_roll) begin
                    async_txd_r <= 1'b0;
                    tx_state_r  <= TXS_START;
                end
                TXS_START: if (tx_roll) begin
                    async_txd_r <= tx_sr_r[0];
                    tx_state_r  <= TXS_DATA;
                end
                TXS_DATA: if (tx_roll) begin
                    tx_sr_r <= {tx_fill, tx_sr_r[8:1]};
                    first_r <= 1'b0;
                    if (tx_finish) begin
                        async_txd_r <= 1'b1;
                        tx_state_r  <= TXS_IDLE;
                    end else begin
                        async_txd_r <= tx_sr_r[1];
                    end
                end
                TXS_SHIFT: if (m0_half) begin
                    if (!m0_phase_r) begin
                        m0_clk_r   <= ~m0_idle;
                        m0_phase_r <= 1'b1;
                    end else begin
                        // data changes as the clock returns to idle
                        m0_clk_r   <= m0_idle;
                        m0_phase_r <= 1'b0;
                        tx_sr_r    <= {1'b0, tx_sr_r[8:1]};
                        m0_dat_r   <= tx_sr_r[1];
                        if (tx_finish) begin
                            m0_dat_r   <= 1'b1;
                            tx_state_r <= TXS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    assign rx_bit    = (smp_a_r & smp_b_r) | (smp_a_r & rxd_s2_r) |
                       (smp_b_r & rxd_s2_r);
    assign rx_fall   = rx_tick && rx_last_r && !rxd_s2_r;
    assign rx_decide = rx_tick && (rx_cnt_r == SAMPLE_C);
    assign m0_sample = rx_m0_r && (tx_state_r == TXS_SHIFT) &&
                       m0_half && m0_phase_r;
    assign m0_final  = m0_sample && !rx_sr_r[7];
    assign as_final  = (rx_state_r == RXS_BITS) && rx_decide &&
                       !rx_first_r && !rx_sr_r[8];
    // last bit shifted is the stop bit (10-bit) or the ninth bit (11-bit)
    assign rx_load   = m0_final || (as_final && !RX_DONE_FLAG &&
                       (!MULTIPROC_GATE || rx_bit));

    always_comb begin
        rx_shift_in = {rx_sr_r[7:0], m0_sample ? din_s2_r : rx_bit};
        rx_byte     = m0_sample ? rev8(rx_shift_in[7:0])
                                : rev8(rx_shift_in[8:1]);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_state_r <= RXS_IDLE;
            rx_sr_r    <= RX_ASYNC_PRELOAD;
            rx_cnt_r   <= '0;
            rx_first_r <= 1'b0;
            rx_last_r  <= 1'b1;
            smp_a_r    <= 1'b1;
            smp_b_r    <= 1'b1;
            rx_m0_r    <= 1'b0;
        end else begin
            if (rx_tick) begin
                rx_cnt_r  <= rx_cnt_r + 1'b1;
                rx_last_r <= rxd_s2_r;
                if (rx_cnt_r == SAMPLE_A) smp_a_r <= rxd_s2_r;
                if (rx_cnt_r == SAMPLE_B) smp_b_r <= rxd_s2_r;
            end
            if (fifo_pop && m0_three && RX_ENABLE) begin
                rx_m0_r <= 1'b1;
                rx_sr_r <= RX_SHIFT_PRELOAD;
            end else if (m0_sample) begin
                rx_sr_r <= rx_shift_in;
                if (m0_final) rx_m0_r <= 1'b0;
            end
            if (MODE == USASP_SHIFT) begin
                rx_state_r <= RXS_IDLE;
            end else begin
                rx_m0_r <= 1'b0;
                unique case (rx_state_r)
                    RXS_IDLE: if (RX_ENABLE && rx_fall) begin
                        rx_cnt_r   <= '0;
                        rx_sr_r    <= RX_ASYNC_PRELOAD;
                        rx_first_r <= 1'b1;
                        rx_state_r <= RXS_BITS;
                    end
                    RXS_BITS: if (rx_decide) begin
                        if (rx_first_r && rx_bit) begin
                            rx_state_r <= RXS_IDLE;
                        end else begin
                            rx_sr_r    <= rx_shift_in;
                            rx_first_r <= 1'b0;
                            if (as_final) begin
                                rx_state_r <= (MODE == USASP_ASYNC10) ?
                                              RXS_IDLE : RXS_HOLD;
                            end
                        end
                    end
                    RXS_HOLD: if (rx_decide) begin
                        rx_state_r <= RXS_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // buffer and flags; a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_BUFFER <= SERIAL_BUFFER_RESET;
            RX_NINTH_BIT  <= 1'b0;
        end else if (rx_load) begin
            SERIAL_BUFFER <= rx_byte;
            if (!m0_sample) RX_NINTH_BIT <= rx_shift_in[0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_DONE_FLAG <= 1'b0;
            RX_DONE_FLAG <= 1'b0;
        end else begin
            TX_DONE_FLAG <= tx_finish | (TX_DONE_FLAG & ~TX_DONE_CLR);
            RX_DONE_FLAG <= rx_load | (RX_DONE_FLAG & ~RX_DONE_CLR);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins; the extra register costs one clock of latency on every pin,
    // so the three-wire loop needs the slower shift rates to close
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TXD_O              <= 1'b1;
            TXD_OE_N           <= 1'b0;
            RXD_O              <= 1'b1;
            RXD_OE_N           <= 1'b1;
            PORT_ONE_BIT_FIVE  <= 1'b1;
            PORT_ONE_BIT_SEVEN <= 1'b1;
            TX_ACTIVE          <= 1'b0;
        end else begin
            TXD_O    <= m0_two ? m0_clk_r : async_txd_r;
            TXD_OE_N <= 1'b0;
            RXD_O    <= m0_dat_r;
            RXD_OE_N <= !(m0_two && (tx_state_r == TXS_SHIFT));
            PORT_ONE_BIT_FIVE  <= m0_three ? m0_dat_r : 1'b1;
            PORT_ONE_BIT_SEVEN <= m0_three ? m0_clk_r : m0_idle;
            TX_ACTIVE <= (tx_state_r != TXS_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            roll_cnt_r <= '0;
        end else if (fifo_pop) begin
            roll_cnt_r <= '0;
        end else if (tx_roll && (tx_state_r != TXS_IDLE)) begin
            roll_cnt_r <= roll_cnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_ti_sticky: assert property (TX_DONE_FLAG && !TX_DONE_CLR |=> TX_DONE_FLAG)
        else $error("tx done flag dropped without clear");
    a_ti_set_wins: assert property (tx_finish |=> TX_DONE_FLAG)
        else $error("tx done flag not set at end of send");
    a_start_bit: assert property ((tx_state_r == TXS_WAIT) && tx_roll && !m0_two
        |-> ##2 !TXD_O ##1 !TXD_O)
        else $error("start bit missing on transmit line");
    a_ten_rolls: assert property (tx_finish && (tx_state_r == TXS_DATA) &&
        (MODE == USASP_ASYNC10) |-> roll_cnt_r == ROLLS_10 - 4'h1)
        else $error("10-bit send did not end at the tenth rollover");
    a_eleven_rolls: assert property (tx_finish && (tx_state_r == TXS_DATA) &&
        MODE[1] |-> roll_cnt_r == ROLLS_11 - 4'h1)
        else $error("11-bit send did not end at rollover eleven");
    a_rx_preload: assert property ((rx_state_r == RXS_IDLE) && rx_fall &&
        RX_ENABLE && (MODE != USASP_SHIFT)
        |=> rx_sr_r == RX_ASYNC_PRELOAD && rx_cnt_r == 4'h0)
        else $error("falling edge did not restart the receiver");
    a_false_start: assert property ((rx_state_r == RXS_BITS) && rx_first_r &&
        rx_decide && rx_bit && (MODE != USASP_SHIFT) |=> rx_state_r == RXS_IDLE)
        else $error("high start bit not rejected");
    a_rx_gate: assert property (as_final && RX_DONE_FLAG
        |=> $stable(SERIAL_BUFFER))
        else $error("buffer overwritten while rx done flag set");
    a_no_recv_m0: assert property ((MODE == USASP_SHIFT) && !rx_m0_r &&
        (rx_state_r == RXS_IDLE) |=> !$rose(RX_DONE_FLAG))
        else $error("rx done flag set without enabled reception");
    a_async_ignored: assert property ((MODE == USASP_SHIFT)
        |=> rx_state_r == RXS_IDLE ##1 rx_state_r == RXS_IDLE || MODE != USASP_SHIFT)
        else $error("async frame accepted in shift mode");
    a_sck_idle: assert property ((tx_state_r != TXS_SHIFT) &&
        $past(tx_state_r != TXS_SHIFT) && $stable(MULTIPROC_GATE)
        |-> m0_clk_r == !MULTIPROC_GATE)
        else $error("shift clock not at its idle level");

    c_rx10_load: cover property (as_final && rx_load && (MODE == USASP_ASYNC10));
    c_tx11_done: cover property (tx_finish && (MODE == USASP_VAR11));
    c_m0_duplex: cover property (m0_final && m0_three);
    c_false_start: cover property ((rx_state_r == RXS_BITS) && rx_first_r &&
        rx_decide && rx_bit);
endmodule

/* File: tb/usasp_uart_node.sv */
// far-side uart node on the asynchronous pins
`timescale 1ns/1ps
module usasp_uart_node #(parameter int BIT_CLKS = 32) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    logic [9:0] got_word;
    initial line_out = 1'b1;
    // frame lsb first, start and stop included
    task automatic send(input logic [10:0] frame, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk) line_out = frame[i];
            repeat (BIT_CLKS - 1) @(negedge clk);
        end
        @(negedge clk) line_out = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // mid-bit samples; after a 10-bit frame the last one is the idle line
    always begin
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            got_word[i] = line_in;
        end
    end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the serial port
`timescale 1ns/1ps
module tb;
    import usasp_pkg::*;
    logic        clk, rst_n, tw, ren, gate, dbl, tx9, t2, ovf, wv, tcl, rcl;
    logic        rxd, txd, b5, b7, wrdy, rx9, txf, rxf, act;
    logic [7:0]  wd, sb, cap, cap2;
    logic        rxo, rxoe, txoe;
    usasp_mode_t mode;
    int          errors = 0, checks_done = 0, cyc = 0, n;
    usasp_serial_port u_dut (
        .CLK(clk), .RST_N(rst_n), .MODE(mode), .THREE_WIRE_ENABLE(tw),
        .RX_ENABLE(ren), .MULTIPROC_GATE(gate), .DOUBLE_RATE_SELECT(dbl),
        .TX_NINTH_BIT(tx9), .TX_CLK_FROM_T2(t2), .RX_CLK_FROM_T2(t2),
        .T1_OVF(ovf), .T2_OVF(ovf), .WR_VALID(wv), .WR_DATA(wd),
        .WR_READY(wrdy), .TX_DONE_CLR(tcl), .RX_DONE_CLR(rcl),
        .SERIAL_BUFFER(sb), .RX_NINTH_BIT(rx9), .TX_DONE_FLAG(txf),
        .RX_DONE_FLAG(rxf), .TX_ACTIVE(act), .RXD_I(rxd), .RXD_O(rxo),
        .RXD_OE_N(rxoe), .TXD_O(txd), .TXD_OE_N(txoe),
        .PORT_ONE_BIT_FIVE(b5), .PORT_ONE_BIT_SIX(b5),
        .PORT_ONE_BIT_SEVEN(b7));
    // three-wire data out loops straight back to data in
    usasp_uart_node #(.BIT_CLKS(32)) u_node (
        .clk(clk), .line_in(txd), .line_out(rxd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // a 16x tick every other clock keeps frames short
    always @(negedge clk) ovf <= cyc[0];
    always @(negedge b7) cap <= {b5, cap[7:1]};
    // two-wire: data on the receive pin while it is driven, clock on txd
    always @(negedge txd) if (!rxoe) cap2 <= {rxo, cap2[7:1]};
    always @(posedge clk) if (++cyc == 12000) results(1);
    task automatic chk(input string s, input logic [10:0] e, g);
        checks_done++;
        if (g !== e) errors++;
        if (g !== e) $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    endtask
    // every write also clears both flags so each scenario starts clean
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        {wv, wd, tcl, rcl} = {1'b1, d, 2'b11};
        do @(posedge clk); while (wrdy !== 1'b1);
        @(negedge clk);
        {wv, tcl, rcl} = 3'b000;
        for (n = 0; n < 1000 && txf !== 1'b1; n++) @(negedge clk);
        repeat (64) @(negedge clk);
    endtask
    task automatic t_async();
        wr(8'ha5);
        chk("tx frame", 11'h3a5, u_node.got_word);
        {ren, gate} = 2'b11;
        u_node.send(11'h278, 10);
        chk("rx word", 11'h33c, {rxf, rx9, sb});
        u_node.send(11'h2aa, 10);
        chk("rx kept", 11'h33c, {rxf, rx9, sb});
        mode = USASP_VAR11;
        {t2, tx9} = 2'b11;
        wr(8'h81);
        chk("tx frame 11", 11'h381, u_node.got_word);
        u_node.send(11'h484, 11);
        chk("rx gated", 11'h13c, {rxf, rx9, sb});
        u_node.send(11'h284, 11);
        chk("rx word 11", 11'h342, {rxf, rx9, sb});
        $display("async test done");
    endtask
    task automatic t_shift();
        mode = USASP_SHIFT;
        // timer rate leaves room for the pin and synchroniser loop delay
        {tw, tx9, gate} = 3'b110;
        wr(8'h96);
        chk("loop word", 11'h396, {rxf, b7, sb});
        chk("wire byte", 8'h96, cap);
        ren = 1'b0;
        wr(8'h5a);
        chk("rx off", 11'h196, {rxf, b7, sb});
        tw = 1'b0;
        wr(8'h3c);
        chk("two-wire byte", 8'h3c, cap2);
        chk("oe idle", 2'b10, {rxoe, txoe});
        tw = 1'b1;
        ren = 1'b1;
        u_node.send(11'h2aa, 10);
        chk("async ignored", 1'b0, rxf);
        $display("shift test done");
    endtask
    task automatic t_fifo();
        {ren, gate, tx9} = 3'b011;
        @(negedge clk);
        wv = 1'b1;
        for (n = 0; wrdy === 1'b1 && n < 12; n++) @(negedge clk);
        wv = 1'b0;
        chk("queue full", 1'b1, n < 12);
        repeat (1500) @(negedge clk);
        chk("queue drained", 11'h4, {wrdy, act, b7});
        $display("fifo test done");
    endtask
    task automatic results(input int late);
        errors += late;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {tw, ren, gate, dbl, tx9, t2, ovf, wv, tcl, rcl, wd} = '0;
        mode = USASP_ASYNC10;
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_async();
        t_shift();
        t_fifo();
        results(0);
    end
endmodule
